// *** rsr_pkg.sv ***
// constants shared by the receiver status readout bank
package rsr_pkg;

    // serial readout addresses
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  ADDR_FLAGS    = 8'hea;
    localparam logic [7:0]  ADDR_GPIO     = 8'heb;
    localparam logic [7:0]  ADDR_CS       = 8'hec;
    localparam logic [7:0]  ADDR_PC       = 8'hed;

    // register widths
    localparam int unsigned FLAGS_W       = 24;
    localparam int unsigned GPIO_W        = 8;
    localparam int unsigned CS_W          = 48;
    localparam int unsigned PC_W          = 16;
    localparam int unsigned SHIFT_W       = 48;

    // stream_format_flags bit positions
    localparam int unsigned FLG_TRANSFER_FAULT = 8;
    localparam int unsigned FLG_RATE_UPDATE    = 10;
    localparam int unsigned FLG_NON_AUDIO      = 12;
    localparam int unsigned FLG_NON_PCM        = 16;
    localparam int unsigned FLG_BURST_SYNC     = 17;
    localparam int unsigned FLG_SIX_CH_SYNC    = 18;
    localparam int unsigned FLG_SEVEN_CH_SYNC  = 19;

    // gpio_levels_and_rate_code layout
    localparam int unsigned PIN_W         = 4;
    localparam int unsigned PIN_LSB       = 0;
    localparam int unsigned RATE_W        = 4;
    localparam int unsigned RATE_LSB      = 4;
    localparam logic        PIN_MODE_PARALLEL = 1'b0;

    // measured rate codes
    localparam logic [3:0]  RATE_OUT_OF_RANGE = 4'h0;
    localparam logic [3:0]  RATE_32K          = 4'h7;
    localparam logic [3:0]  RATE_44K1         = 4'h8;
    localparam logic [3:0]  RATE_48K          = 4'h9;
    localparam logic [3:0]  RATE_192K         = 4'hf;

    // channel status capture
    localparam int unsigned CS_IDX_W      = 6;
    localparam logic [5:0]  CS_IDX_FIRST  = 6'h00;
    localparam logic [5:0]  CS_IDX_NONPCM = 6'h01;
    localparam logic [5:0]  CS_IDX_LAST   = 6'h2f;
    localparam logic [5:0]  CS_IDX_DONE   = 6'h30;
    localparam logic [5:0]  CS_IDX_STEP   = 6'h01;

    // burst preamble word layout
    localparam int unsigned PC_RSVD_LSB   = 5;
    localparam int unsigned PC_RSVD_MSB   = 6;
    localparam int unsigned PC_ERR_BIT    = 7;

    // frozen snapshot layout
    localparam int unsigned SNAP_FLAGS_LSB = 0;
    localparam int unsigned SNAP_GPIO_LSB  = 24;
    localparam int unsigned SNAP_CS_LSB    = 32;
    localparam int unsigned SNAP_PC_LSB    = 80;
    localparam int unsigned SNAP_W         = 96;

endpackage : rsr_pkg

// *** rsr_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module rsr_sync #(
    parameter int unsigned W = 1
) (
    // destination clock
    input  wire logic         clk,
    // asynchronous level in, synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        meta_r <= d;
        q      <= meta_r;
    end

endmodule // rsr_sync

`default_nettype wire

// *** rsr_status_bank.sv ***
// read-only status bank of the audio interface receiver with its serial readout
`timescale 1ns/1ps
`default_nettype none

module rsr_status_bank
    import rsr_pkg::*;
(
    // system clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // serial control link from the host
    input  wire logic              ser_clk,
    input  wire logic              ser_ce,
    input  wire logic              ser_di,
    output logic                   ser_do,
    // error and audio status sources
    input  wire logic              fault_src_lock,
    input  wire logic              fault_src_data,
    input  wire logic              non_audio_src_lock,
    input  wire logic              non_audio_src_data,
    input  wire logic              status_source_select,
    // channel status stream
    input  wire logic              cs_bit,
    input  wire logic              cs_bit_strobe,
    input  wire logic              cs_block_start,
    // burst detection and preamble word
    input  wire logic              burst_sync_det,
    input  wire logic              six_ch_sync_det,
    input  wire logic              seven_ch_sync_det,
    input  wire logic [PC_W-1:0]   pc_word,
    input  wire logic              pc_strobe,
    // sample rate measurement
    input  wire logic [RATE_W-1:0] measured_rate_code,
    input  wire logic              rate_done,
    // general purpose pins
    input  wire logic [PIN_W-1:0]  aux_pin,
    input  wire logic              aux_pin_mode_select
);

    // unused codes between out of range and 32 kHz read as out of range
    function automatic logic [RATE_W-1:0] rate_clean(input logic [RATE_W-1:0] code);
        logic [RATE_W-1:0] res;
        res = code;
        if (code != RATE_OUT_OF_RANGE && code < RATE_32K) begin
            res = RATE_OUT_OF_RANGE;
        end
        return res;
    endfunction

    // picks the lock or data flavoured source of a status flag
    function automatic logic src_pick(input logic sel,
                                      input logic lock_src,
                                      input logic data_src);
        logic res;
        res = sel ? data_src : lock_src;
        return res;
    endfunction

    // picks the frozen register that an address names, zero when unmapped
    function automatic logic [SHIFT_W-1:0] reg_select(input logic [ADDR_W-1:0] addr,
                                                      input logic [SNAP_W-1:0] snap);
        logic [SHIFT_W-1:0] res;
        res = '0;
        case (addr)
            ADDR_FLAGS: res[FLAGS_W-1:0] = snap[SNAP_FLAGS_LSB +: FLAGS_W];
            ADDR_GPIO:  res[GPIO_W-1:0]  = snap[SNAP_GPIO_LSB +: GPIO_W];
            ADDR_CS:    res[CS_W-1:0]    = snap[SNAP_CS_LSB +: CS_W];
            ADDR_PC:    res[PC_W-1:0]    = snap[SNAP_PC_LSB +: PC_W];
            default:    res = '0;
        endcase
        return res;
    endfunction

    // crossings
    // pins and the enable pass two flops; the read event crosses as a toggle
    // the snapshot is held still by the enable, so its bits need no flops
    logic              ce_ref;
    logic [PIN_W-1:0]  pin_ref;
    logic              rd_tog_ref;
    logic              link_rst_n;
    logic              rd_tog_r;

    // chip enable tells the system side when a readout is in progress
    rsr_sync #(.W(1)) u_ce_sync (
        .clk (ref_clk),
        .d   (ser_ce),
        .q   (ce_ref)
    );

    // pins arrive from outside and are synchronised before use
    rsr_sync #(.W(PIN_W)) u_pin_sync (
        .clk (ref_clk),
        .d   (aux_pin),
        .q   (pin_ref)
    );

    // flag register read event, sent as a toggle
    rsr_sync #(.W(1)) u_rd_sync (
        .clk (ref_clk),
        .d   (rd_tog_r),
        .q   (rd_tog_ref)
    );

    // reset brought into the link clock domain
    rsr_sync #(.W(1)) u_rst_sync (
        .clk (ser_clk),
        .d   (rst_n),
        .q   (link_rst_n)
    );

    // system side: stream flags and rate measurement
    // every flag is registered once so the snapshot only sees settled values
    // the rate flag is the only one that the host clears by reading
    logic              fault_r,      fault_nxt;
    logic              non_audio_r,  non_audio_nxt;
    logic              burst_r,      burst_nxt;
    logic              six_ch_r,     six_ch_nxt;
    logic              seven_ch_r,   seven_ch_nxt;
    logic              rate_flag_r,  rate_flag_nxt;
    logic              rate_fresh_r, rate_fresh_nxt;
    logic [RATE_W-1:0] rate_code_r,  rate_code_nxt;
    logic [PIN_W-1:0]  pins_r,       pins_nxt;
    logic              rd_tog_d_r,   rd_tog_d_nxt;
    logic              rate_clr;
    logic [SNAP_W-1:0] snap_r,       snap_nxt;

    // next values of flags; a new measurement beats a clear in the same cycle
    always_comb begin
        fault_nxt     = src_pick(status_source_select, fault_src_lock, fault_src_data);
        non_audio_nxt = src_pick(status_source_select, non_audio_src_lock, non_audio_src_data);
        burst_nxt     = burst_sync_det;
        six_ch_nxt    = six_ch_sync_det;
        seven_ch_nxt  = seven_ch_sync_det;
        rd_tog_d_nxt  = rd_tog_ref;
        // clear only what the host actually saw in its frozen copy
        rate_clr      = (rd_tog_ref != rd_tog_d_r) && snap_r[SNAP_FLAGS_LSB + FLG_RATE_UPDATE] && !rate_fresh_r;
        // a measurement landing after the freeze is newer than the host's copy
        rate_fresh_nxt = rate_done | (ce_ref & rate_fresh_r);
        rate_flag_nxt = rate_done | (rate_flag_r & ~rate_clr);
        rate_code_nxt = rate_done ? rate_clean(measured_rate_code) : rate_code_r;
        // pins read as zero outside parallel input mode
        pins_nxt      = (aux_pin_mode_select == PIN_MODE_PARALLEL) ? pin_ref : '0;
    end

    // flag registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fault_r     <= 1'b0;
            non_audio_r <= 1'b0;
            burst_r     <= 1'b0;
            six_ch_r    <= 1'b0;
            seven_ch_r  <= 1'b0;
            rate_flag_r <= 1'b0;
            rate_fresh_r <= 1'b0;
            rate_code_r <= RATE_OUT_OF_RANGE;
            pins_r      <= '0;
            rd_tog_d_r  <= 1'b0;
        end else begin
            fault_r     <= fault_nxt;
            non_audio_r <= non_audio_nxt;
            burst_r     <= burst_nxt;
            six_ch_r    <= six_ch_nxt;
            seven_ch_r  <= seven_ch_nxt;
            rate_flag_r <= rate_flag_nxt;
            rate_fresh_r <= rate_fresh_nxt;
            rate_code_r <= rate_code_nxt;
            pins_r      <= pins_nxt;
            rd_tog_d_r  <= rd_tog_d_nxt;
        end
    end

    // system side: channel status capture
    // bits gather in a working copy and are stored whole at the last index
    // so the host never sees a half-updated block
    logic [CS_IDX_W-1:0] cs_idx_r,   cs_idx_nxt;
    logic [CS_W-1:0]     cs_work_r,  cs_work_nxt;
    logic [CS_W-1:0]     cs_cap_r,   cs_cap_nxt;
    logic                non_pcm_r,  non_pcm_nxt;
    logic [CS_IDX_W-1:0] cs_pos;

    // collects bits of each block; a completed block is dropped while frozen
    always_comb begin
        cs_idx_nxt  = cs_idx_r;
        cs_work_nxt = cs_work_r;
        cs_cap_nxt  = cs_cap_r;
        non_pcm_nxt = non_pcm_r;
        cs_pos      = cs_block_start ? CS_IDX_FIRST : cs_idx_r;
        if (cs_bit_strobe) begin
            if (cs_pos <= CS_IDX_LAST) begin
                cs_work_nxt[cs_pos] = cs_bit;
                cs_idx_nxt          = cs_pos + CS_IDX_STEP;
            end
            if (cs_pos == CS_IDX_NONPCM) begin
                non_pcm_nxt = cs_bit;
            end
            if (cs_pos == CS_IDX_LAST && !ce_ref) begin
                cs_cap_nxt = cs_work_nxt;
            end
        end
    end

    // channel status registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cs_idx_r  <= CS_IDX_DONE;
            cs_work_r <= '0;
            cs_cap_r  <= '0;
            non_pcm_r <= 1'b0;
        end else begin
            cs_idx_r  <= cs_idx_nxt;
            cs_work_r <= cs_work_nxt;
            cs_cap_r  <= cs_cap_nxt;
            non_pcm_r <= non_pcm_nxt;
        end
    end

    // system side: burst preamble word
    // one word wide, taken on its strobe
    // reserved bits are forced low so a noisy source cannot leak into them
    logic [PC_W-1:0] pc_r, pc_nxt;

    // keeps field positions as received; reserved bits forced low
    always_comb begin
        pc_nxt = pc_r;
        if (pc_strobe) begin
            pc_nxt                          = pc_word;
            pc_nxt[PC_RSVD_MSB:PC_RSVD_LSB] = '0;
        end
    end

    // preamble register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pc_r <= '0;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    // system side: snapshot held still while the host reads
    // enable high freezes every register at once, not only channel status
    // this keeps the link side free of reads of moving bits
    logic [FLAGS_W-1:0] flags_live;

    // live view of all four registers; frozen whenever chip enable is high
    always_comb begin
        flags_live                     = '0;
        flags_live[FLG_TRANSFER_FAULT] = fault_r;
        flags_live[FLG_RATE_UPDATE]    = rate_flag_r;
        flags_live[FLG_NON_AUDIO]      = non_audio_r;
        flags_live[FLG_NON_PCM]        = non_pcm_r;
        flags_live[FLG_BURST_SYNC]     = burst_r;
        flags_live[FLG_SIX_CH_SYNC]    = six_ch_r;
        flags_live[FLG_SEVEN_CH_SYNC]  = seven_ch_r;
        snap_nxt = snap_r;
        if (!ce_ref) begin
            snap_nxt[SNAP_FLAGS_LSB +: FLAGS_W] = flags_live;
            snap_nxt[SNAP_GPIO_LSB + PIN_LSB +: PIN_W]   = pins_r;
            snap_nxt[SNAP_GPIO_LSB + RATE_LSB +: RATE_W] = rate_code_r;
            snap_nxt[SNAP_CS_LSB +: CS_W]       = cs_cap_r;
            snap_nxt[SNAP_PC_LSB +: PC_W]       = pc_r;
        end
    end

    // snapshot register read by the link side
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            snap_r <= '0;
        end else begin
            snap_r <= snap_nxt;
        end
    end

    // link side: address shift, data shift
    // runs only while the host clocks it; the clock may stop between frames
    // reset arrives through its own two-flop chain
    logic [ADDR_W-1:0]  addr_r,    addr_nxt;
    logic [SHIFT_W-1:0] sh_r,      sh_nxt;
    logic               in_data_r, in_data_nxt;
    logic               rd_tog_nxt;

    // address bits enter lsb first with enable low; data leaves lsb first with it high
    always_comb begin
        addr_nxt    = addr_r;
        sh_nxt      = sh_r;
        in_data_nxt = in_data_r;
        rd_tog_nxt  = rd_tog_r;
        if (!ser_ce) begin
            addr_nxt    = {ser_di, addr_r[ADDR_W-1:1]};
            sh_nxt      = '0;
            in_data_nxt = 1'b0;
        end else if (!in_data_r) begin
            // snapshot is stable: the system side froze it on the enable edge
            sh_nxt      = reg_select(addr_r, snap_r);
            in_data_nxt = 1'b1;
            if (addr_r == ADDR_FLAGS) begin
                rd_tog_nxt = ~rd_tog_r;
            end
        end else begin
            sh_nxt = {1'b0, sh_r[SHIFT_W-1:1]};
        end
    end

    // link registers on the host clock
    always_ff @(posedge ser_clk) begin
        if (!link_rst_n) begin
            addr_r    <= '0;
            sh_r      <= '0;
            in_data_r <= 1'b0;
            rd_tog_r  <= 1'b0;
        end else begin
            addr_r    <= addr_nxt;
            sh_r      <= sh_nxt;
            in_data_r <= in_data_nxt;
            rd_tog_r  <= rd_tog_nxt;
        end
    end

    // serial data out is the low bit of the shift register
    assign ser_do = sh_r[0];

endmodule // rsr_status_bank

`default_nettype wire

// *** rsr_assertions.sv ***
// concurrent checks on the serial readout of the status bank
`timescale 1ns/1ps
`default_nettype none
module rsr_assertions
    import rsr_pkg::*;
(
    // reset and link clock
    input wire logic rst_n,
    input wire logic ser_clk,
    // serial link
    input wire logic ser_ce,
    input wire logic ser_di,
    input wire logic ser_do
);
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    // follow the address shifted in and the index of the bit on ser_do
    always_comb begin
        addr_nxt = !rst_n ? 8'h00 : ser_ce ? addr_r : {ser_di, addr_r[7:1]};
        cnt_nxt  = (!rst_n || !ser_ce) ? 7'h00 : (cnt_r == 7'h7f) ? cnt_r : cnt_r + 7'h01;
    end
    // helper registers only
    always_ff @(posedge ser_clk) begin
        addr_r <= addr_nxt;
        cnt_r  <= cnt_nxt;
    end
    default clocking cb @(posedge ser_clk); endclocking
    default disable iff (!rst_n);
    property p_addr_quiet; !ser_ce |=> !ser_do; endproperty
    a_addr_quiet: assert property (p_addr_quiet)
        else $error("data out active in address phase");
    property p_unmapped;
        ser_ce && cnt_r == 7'h00 && !(addr_r inside {[ADDR_FLAGS:ADDR_PC]}) |=> !ser_do [*8];
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address reads non zero");
    property p_flags_top; ser_ce && addr_r == ADDR_FLAGS && cnt_r inside {[7'd20:7'd23]} |=> !ser_do; endproperty
    a_flags_top: assert property (p_flags_top)
        else $error("flag bits 20 to 23 not zero");
    property p_flags_low;
        ser_ce && addr_r == ADDR_FLAGS && cnt_r inside {[7'd0:7'd7], 7'd9, 7'd11, [7'd13:7'd15]} |=> !ser_do;
    endproperty
    a_flags_low: assert property (p_flags_low)
        else $error("unused flag bit not zero");
    property p_flags_end; ser_ce && addr_r == ADDR_FLAGS && cnt_r >= 7'd24 |=> !ser_do; endproperty
    a_flags_end: assert property (p_flags_end)
        else $error("flags read past width not zero");
    property p_rate_end; ser_ce && addr_r == ADDR_GPIO && cnt_r >= 7'd8 |=> !ser_do; endproperty
    a_rate_end: assert property (p_rate_end)
        else $error("pin and rate byte read past width not zero");
    property p_cs_end; ser_ce && addr_r == ADDR_CS && cnt_r >= 7'd48 |=> !ser_do; endproperty
    a_cs_end: assert property (p_cs_end)
        else $error("channel status read past 48 bits not zero");
    property p_pc_rsvd; ser_ce && addr_r == ADDR_PC && cnt_r inside {7'd5, 7'd6} |=> !ser_do; endproperty
    a_pc_rsvd: assert property (p_pc_rsvd)
        else $error("reserved preamble bits not zero");
    property p_pc_end; ser_ce && addr_r == ADDR_PC && cnt_r >= 7'd16 |=> !ser_do; endproperty
    a_pc_end: assert property (p_pc_end)
        else $error("preamble read past 16 bits not zero");
    // main readouts reached
    c_cs: cover property (ser_ce && addr_r == ADDR_CS && cnt_r == 7'd47);
    c_pc: cover property (ser_ce && addr_r == ADDR_PC && cnt_r == 7'd15);
    c_flags: cover property (ser_ce && addr_r == ADDR_FLAGS && cnt_r == 7'd23);
endmodule // rsr_assertions
`default_nettype wire

// *** rsr_host_model.sv ***
// host side serial master that reads the status bank
`timescale 1ns/1ps
`default_nettype none
module rsr_host_model (
    // serial link driven by the host
    output logic      ser_clk,
    output logic      ser_ce,
    output logic      ser_di,
    // readout data from the bank
    input  wire logic ser_do
);
    localparam int HALF = 80;
    // link idles with its clock stopped low
    initial begin
        ser_clk = 1'b0;
        ser_ce = 1'b0;
        ser_di = 1'b0;
    end
    // clock pulses with chip enable low, used around reset
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #HALF ser_clk = 1'b1;
            #HALF ser_clk = 1'b0;
        end
    endtask
    // one frame: address lsb first, then n data clocks sampled after each fall
    task automatic read_reg(input logic [7:0] a, input int n, output logic [47:0] d);
        d = '0;
        #1.3;
        for (int i = 0; i < 8; i++) begin
            ser_di = a[i];
            #HALF ser_clk = 1'b1;
            #HALF ser_clk = 1'b0;
        end
        ser_ce = 1'b1;
        #100;
        for (int i = 0; i < n; i++) begin
            ser_di = ~ser_di; // data line is unused here, keep it moving
            ser_clk = 1'b1;
            #HALF ser_clk = 1'b0;
            if (i < $bits(d)) begin
                d[i] = ser_do; // bits past the kept width are clocked but dropped
            end
            #HALF;
        end
        ser_ce = 1'b0;
        #40;
    endtask
endmodule // rsr_host_model
`default_nettype wire

// *** testbench.sv ***
// self-checking bench of the receiver status readout bank
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rsr_pkg::*;
;
    localparam logic [47:0] CS_A = 48'h5a3c_96e1_f00f;
    logic            ref_clk, rst_n, ser_clk, ser_ce, ser_di, ser_do;
    logic            flt_lock, flt_data, na_lock, na_data, src_sel, pin_mode;
    logic            cs_bit, cs_stb, cs_start, burst, six_ch, seven_ch, pc_stb, rate_done;
    logic [PC_W-1:0] pc_word;
    logic [3:0]      rate_code, aux_pin;
    logic [47:0]     rd;
    int              failures, num_checks, cycles;

    rsr_status_bank DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_ce(ser_ce),
        .ser_di(ser_di), .ser_do(ser_do), .fault_src_lock(flt_lock), .fault_src_data(flt_data),
        .non_audio_src_lock(na_lock), .non_audio_src_data(na_data), .status_source_select(src_sel),
        .cs_bit(cs_bit), .cs_bit_strobe(cs_stb), .cs_block_start(cs_start), .burst_sync_det(burst),
        .six_ch_sync_det(six_ch), .seven_ch_sync_det(seven_ch), .pc_word(pc_word), .pc_strobe(pc_stb),
        .measured_rate_code(rate_code), .rate_done(rate_done), .aux_pin(aux_pin),
        .aux_pin_mode_select(pin_mode));
    rsr_host_model u_host (.ser_clk(ser_clk), .ser_ce(ser_ce), .ser_di(ser_di), .ser_do(ser_do));

    // system clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            test_done();
        end
    end
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // both status sources and all detector bits
    task automatic t_flags();
        logic s;
        for (int k = 0; k < 2; k++) begin
            s = k[0];
            step();
            src_sel = s;
            burst = !s;
            six_ch = s;
            seven_ch = !s;
            repeat (10) step();
            u_host.read_reg(ADDR_FLAGS, 28, rd);
            check(rd, {28'h0, !s, s, !s, 4'h0, s, 3'h0, !s, 8'h00});
        end
    endtask
    // every rate code, pin levels in and out of parallel mode, then the update flag
    task automatic t_rate();
        for (int i = 0; i < 16; i++) begin
            step();
            rate_code = i[3:0];
            aux_pin = ~i[3:0];
            pin_mode = (i == 5);
            rate_done = 1'b1;
            step();
            rate_done = 1'b0;
            repeat (10) step();
            u_host.read_reg(ADDR_GPIO, 12, rd);
            check(rd, {40'h0, (i > 0 && i < 7) ? 4'h0 : i[3:0], (i == 5) ? 4'h0 : ~i[3:0]});
        end
        u_host.read_reg(ADDR_FLAGS, 24, rd);
        check({47'h0, rd[FLG_RATE_UPDATE]}, 48'h1);
        u_host.read_reg(ADDR_FLAGS, 24, rd);
        check({47'h0, rd[FLG_RATE_UPDATE]}, 48'h0);
    endtask
    task automatic send_block(input logic [47:0] p);
        for (int i = 0; i < 48; i++) begin
            step();
            cs_bit = p[i];
            cs_stb = 1'b1;
            cs_start = (i == 0);
            step();
            cs_stb = 1'b0;
            cs_start = 1'b0;
        end
    endtask
    // capture, bit order, non-pcm flag and freeze during a readout
    task automatic t_cs();
        send_block(CS_A);
        repeat (10) step();
        u_host.read_reg(ADDR_CS, 52, rd);
        check(rd, CS_A);
        u_host.read_reg(ADDR_FLAGS, 24, rd);
        check({47'h0, rd[FLG_NON_PCM]}, {47'h0, CS_A[1]});
        fork
            u_host.read_reg(ADDR_CS, 48, rd);
            begin
                #2000;
                send_block(~CS_A);
            end
        join
        check(rd, CS_A);
    endtask
    task automatic t_pc(input logic [15:0] w, input logic [15:0] exp);
        step();
        pc_word = w;
        pc_stb = 1'b1;
        step();
        pc_stb = 1'b0;
        repeat (10) step();
        u_host.read_reg(ADDR_PC, 20, rd);
        check(rd, {32'h0, exp});
    endtask
    task automatic t_unmapped();
        u_host.read_reg(8'hee, 48, rd);
        check(rd, 48'h0);
    endtask
    // reset with link clocks running, then the scenarios
    initial begin
        {rst_n, flt_data, na_lock, src_sel, pin_mode, cs_bit, cs_stb, cs_start} = '0;
        {burst, six_ch, seven_ch, pc_stb, rate_done, pc_word, rate_code, aux_pin} = '0;
        flt_lock = 1'b1;
        na_data = 1'b1;
        failures = 0;
        num_checks = 0;
        cycles = 0;
        fork
            repeat (8) step();
            u_host.idle_clocks(4);
        join
        step();
        rst_n = 1'b1;
        u_host.idle_clocks(4);
        t_flags();
        t_rate();
        t_cs();
        t_pc(16'hffff, 16'hff9f);
        t_pc(16'h1a05, 16'h1a05);
        t_unmapped();
        test_done();
    end
endmodule // testbench
bind rsr_status_bank rsr_assertions u_chk (.rst_n(rst_n), .ser_clk(ser_clk), .ser_ce(ser_ce),
    .ser_di(ser_di), .ser_do(ser_do));
`default_nettype wire
